// ---- pwm_timer_pkg.sv ----
// Purpose: Shared constants for the pulse width measurement timer
// Assumes: 8-bit register port, 8-bit prescaler and timer
// Notes: Offsets are word indices on the plain register port
package pwm_timer_pkg;
  localparam logic [2:0] ADDR_MODE = 3'h0;
  localparam logic [2:0] ADDR_PRESCALER = 3'h1;
  localparam logic [2:0] ADDR_TIMER = 3'h2;
  localparam logic [2:0] ADDR_PIN_CONFIG = 3'h3;
  localparam logic [2:0] ADDR_INT_STATUS = 3'h4;
  localparam logic [2:0] ADDR_INT_MASK = 3'h5;
  localparam int MODE_RUN_BIT = 0;
  localparam int MODE_POL_BIT = 1;
  localparam int MODE_SRC_LSB = 4;
  localparam int PINCFG_SEL_BIT = 0;
  localparam int IRQ_UNDERFLOW_BIT = 0;
  localparam int IRQ_EDGE_BIT = 1;
  localparam logic [7:0] PRESCALER_RESET = 8'hff;
  localparam logic [7:0] TIMER_RESET = 8'hff;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [1:0] SRC_DIV1 = 2'h0;
  localparam logic [1:0] SRC_DIV2 = 2'h1;
  localparam logic [1:0] SRC_DIV8 = 2'h2;
  localparam logic [1:0] SRC_RING = 2'h3;
  localparam logic [2:0] DIV8_LAST = 3'h7;
endpackage

// ---- pwm_sync2.sv ----
// Purpose: Two-stage synchroniser for an asynchronous level
// Assumes: Destination clock is clk_sys_i
// Notes: First stage is read only by the second
`timescale 1ns/100ps
module pwm_sync2 (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic async_i,
  output logic sync_o
);
  logic meta_ff;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      meta_ff <= 1'b0;
      sync_o <= 1'b0;
    end else begin
      meta_ff <= async_i;
      sync_o <= meta_ff;
    end
  end
endmodule

// ---- pwm_tick_gen.sv ----
// Purpose: Count source tick generator
// Assumes: Ring oscillator level already synchronised
// Notes: One-cycle tick per selected source period
`timescale 1ns/100ps
module pwm_tick_gen (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [1:0] src_sel_i,
  input wire logic ring_sync_i,
  output logic tick_o
);
  logic [2:0] div_ff;
  logic ring_d_ff;
  logic nxt_tick;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      div_ff <= 3'h0;
      ring_d_ff <= 1'b0;
    end else begin
      div_ff <= div_ff + 3'h1;
      ring_d_ff <= ring_sync_i;
    end
  end
  always_comb begin
    case (src_sel_i)
      pwm_timer_pkg::SRC_DIV1: nxt_tick = 1'b1;
      pwm_timer_pkg::SRC_DIV2: nxt_tick = div_ff[0];
      pwm_timer_pkg::SRC_DIV8: nxt_tick = (div_ff == pwm_timer_pkg::DIV8_LAST);
      default: nxt_tick = ring_sync_i & ~ring_d_ff;
    endcase
  end
  assign tick_o = nxt_tick;
endmodule

// ---- pwm_timer.sv ----
// Purpose: Pulse width measurement mode of a down-counting timer with prescaler
// Assumes: Pins and ring oscillator are asynchronous; register port on clk_sys_i
// Notes: Reads return data the cycle after the read strobe
// Notes on behaviour
// - The counter decrements on count ticks only while the input is at the chosen level.
// - On underflow the counter reloads from the reload register and keeps running.
// - Writing one to the run bit starts counting.
// - Writing zero to the run bit stops counting.
// - Every timer underflow raises the timer interrupt.
// - The input edge ending a measured period raises the external edge interrupt.
// - The selected pin feeds both the count gate and the edge interrupt.
// - A pin configuration bit chooses between two measurement pins.
// - Reading timer and prescaler returns the live count.
// - A write while stopped loads both reload register and counter.
// - A write while running reaches the reload on tick one, the counter on tick two, the sequencer idles on tick three, counting resumes on tick four.
// - The polarity bit picks whether the high or low period is measured.
//
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/100ps
module pwm_timer (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic measure_input_pin_a_i,
  input wire logic measure_input_pin_b_i,
  input wire logic ring_osc_clock_i,
  output logic irq_o,
  output logic timer_irq_o,
  output logic external_edge_interrupt_o
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_LATCH = 4'b0010,
    ST_XFER = 4'b0100,
    ST_RESUME = 4'b1000
  } stage_e;

  logic pin_a_sync;
  logic pin_b_sync;
  logic ring_sync;
  logic tick;
  logic [7:0] mode_reg_ff;
  logic [7:0] pin_config_reg_ff;
  logic [7:0] pre_reload_ff;
  logic [7:0] tmr_reload_ff;
  logic [7:0] pre_cnt_ff;
  logic [7:0] tmr_cnt_ff;
  logic [7:0] pre_pend_ff;
  logic [7:0] tmr_pend_ff;
  logic [1:0] int_status_ff;
  logic [1:0] int_mask_ff;
  logic meas_d_ff;
  logic irq_ff;
  logic timer_irq_ff;
  logic edge_irq_ff;
  logic [7:0] rdata_ff;
  stage_e stage_ff;
  stage_e nxt_stage;
  logic run;
  logic polarity;
  logic measure_input;
  logic gate;
  logic count_en;
  logic pre_under;
  logic tmr_under;
  logic end_edge;
  logic wr_pre;
  logic wr_tmr;
  logic wr_mode;
  logic wr_pin_cfg;
  logic wr_mask;
  logic wr_status;
  logic clr_under;
  logic clr_edge;
  logic edge_set;

  pwm_sync2 u_sync_a (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i(measure_input_pin_a_i),
    .sync_o(pin_a_sync)
  );
  pwm_sync2 u_sync_b (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i(measure_input_pin_b_i),
    .sync_o(pin_b_sync)
  );
  pwm_sync2 u_sync_ring (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .async_i(ring_osc_clock_i),
    .sync_o(ring_sync)
  );
  pwm_tick_gen u_tick (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .src_sel_i(mode_reg_ff[pwm_timer_pkg::MODE_SRC_LSB +: 2]),
    .ring_sync_i(ring_sync),
    .tick_o(tick)
  );

  assign run = mode_reg_ff[pwm_timer_pkg::MODE_RUN_BIT];
  assign polarity = mode_reg_ff[pwm_timer_pkg::MODE_POL_BIT];
  assign wr_pre = wr_i && (addr_i == pwm_timer_pkg::ADDR_PRESCALER);
  assign wr_tmr = wr_i && (addr_i == pwm_timer_pkg::ADDR_TIMER);
  assign wr_mode = wr_i && (addr_i == pwm_timer_pkg::ADDR_MODE);
  assign wr_pin_cfg = wr_i && (addr_i == pwm_timer_pkg::ADDR_PIN_CONFIG);
  assign wr_mask = wr_i && (addr_i == pwm_timer_pkg::ADDR_INT_MASK);
  assign wr_status = wr_i && (addr_i == pwm_timer_pkg::ADDR_INT_STATUS);
  assign clr_under = wr_status && wdata_i[pwm_timer_pkg::IRQ_UNDERFLOW_BIT];
  assign clr_edge = wr_status && wdata_i[pwm_timer_pkg::IRQ_EDGE_BIT];
  assign edge_set = run && end_edge;

  // Pin choice feeds gate and edge detector alike
  assign measure_input = pin_config_reg_ff[pwm_timer_pkg::PINCFG_SEL_BIT] ? pin_b_sync : pin_a_sync;
  assign gate = (measure_input == polarity);
  assign count_en = run && tick && gate && (stage_ff == ST_IDLE);
  assign pre_under = count_en && (pre_cnt_ff == 8'h00);
  assign tmr_under = pre_under && (tmr_cnt_ff == 8'h00);
  // Leaving the measured level ends a period
  assign end_edge = (meas_d_ff == polarity) && (measure_input != polarity);

  // Mode register
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      mode_reg_ff <= pwm_timer_pkg::MODE_RESET;
    end else if (wr_mode) begin
      mode_reg_ff <= wdata_i & 8'h33;
    end
  end

  // Pin configuration register
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pin_config_reg_ff <= 8'h00;
    end else if (wr_pin_cfg) begin
      pin_config_reg_ff <= {7'h00, wdata_i[pwm_timer_pkg::PINCFG_SEL_BIT]};
    end
  end

  // Interrupt mask register
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      int_mask_ff <= 2'h0;
    end else if (wr_mask) begin
      int_mask_ff <= wdata_i[1:0];
    end
  end

  // Staged reload sequencer for writes while running
  always_comb begin
    nxt_stage = stage_ff;
    case (stage_ff)
      ST_IDLE: if (run && (wr_pre || wr_tmr)) nxt_stage = ST_LATCH;
      ST_LATCH: if (tick) nxt_stage = ST_XFER;
      ST_XFER: if (tick) nxt_stage = ST_RESUME;
      ST_RESUME: if (tick) nxt_stage = ST_IDLE;
      default: nxt_stage = ST_IDLE;
    endcase
    if (!run) begin
      nxt_stage = ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      stage_ff <= ST_IDLE;
    end else begin
      stage_ff <= nxt_stage;
    end
  end

  // Pending write values
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pre_pend_ff <= pwm_timer_pkg::PRESCALER_RESET;
      tmr_pend_ff <= pwm_timer_pkg::TIMER_RESET;
    end else begin
      if (wr_pre) begin
        pre_pend_ff <= wdata_i;
      end
      if (wr_tmr) begin
        tmr_pend_ff <= wdata_i;
      end
    end
  end

  // Reload registers
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pre_reload_ff <= pwm_timer_pkg::PRESCALER_RESET;
      tmr_reload_ff <= pwm_timer_pkg::TIMER_RESET;
    end else if (!run) begin
      if (wr_pre) begin
        pre_reload_ff <= wdata_i;
      end
      if (wr_tmr) begin
        tmr_reload_ff <= wdata_i;
      end
    end else if (stage_ff == ST_LATCH && tick) begin
      pre_reload_ff <= pre_pend_ff;
      tmr_reload_ff <= tmr_pend_ff;
    end
  end

  // Prescaler and timer counters
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pre_cnt_ff <= pwm_timer_pkg::PRESCALER_RESET;
      tmr_cnt_ff <= pwm_timer_pkg::TIMER_RESET;
    end else if (!run) begin
      if (wr_pre) begin
        pre_cnt_ff <= wdata_i;
      end
      if (wr_tmr) begin
        tmr_cnt_ff <= wdata_i;
      end
    end else if (stage_ff == ST_XFER && tick) begin
      pre_cnt_ff <= pre_reload_ff;
      tmr_cnt_ff <= tmr_reload_ff;
    end else if (count_en) begin
      if (pre_under) begin
        pre_cnt_ff <= pre_reload_ff;
        if (tmr_under) begin
          tmr_cnt_ff <= tmr_reload_ff;
        end else begin
          tmr_cnt_ff <= tmr_cnt_ff - 8'h01;
        end
      end else begin
        pre_cnt_ff <= pre_cnt_ff - 8'h01;
      end
    end
  end

  // Edge detector history
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      meas_d_ff <= 1'b0;
    end else begin
      meas_d_ff <= measure_input;
    end
  end

  // Sticky status, set wins over write-one clear
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      int_status_ff <= 2'h0;
    end else begin
      int_status_ff[pwm_timer_pkg::IRQ_UNDERFLOW_BIT] <= tmr_under ||
        (int_status_ff[pwm_timer_pkg::IRQ_UNDERFLOW_BIT] && !clr_under);
      int_status_ff[pwm_timer_pkg::IRQ_EDGE_BIT] <= edge_set ||
        (int_status_ff[pwm_timer_pkg::IRQ_EDGE_BIT] && !clr_edge);
    end
  end

  // Combined level request
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= |(int_status_ff & int_mask_ff);
    end
  end

  // Underflow pulse
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      timer_irq_ff <= 1'b0;
    end else begin
      timer_irq_ff <= tmr_under;
    end
  end

  // End-of-period pulse
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      edge_irq_ff <= 1'b0;
    end else begin
      edge_irq_ff <= edge_set;
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_ff <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        pwm_timer_pkg::ADDR_MODE: rdata_ff <= mode_reg_ff;
        pwm_timer_pkg::ADDR_PRESCALER: rdata_ff <= pre_cnt_ff;
        pwm_timer_pkg::ADDR_TIMER: rdata_ff <= tmr_cnt_ff;
        pwm_timer_pkg::ADDR_PIN_CONFIG: rdata_ff <= pin_config_reg_ff;
        pwm_timer_pkg::ADDR_INT_STATUS: rdata_ff <= {6'h00, int_status_ff};
        pwm_timer_pkg::ADDR_INT_MASK: rdata_ff <= {6'h00, int_mask_ff};
        default: rdata_ff <= 8'h00;
      endcase
    end else begin
      rdata_ff <= 8'h00;
    end
  end

  assign rdata_o = rdata_ff;
  assign irq_o = irq_ff;
  assign timer_irq_o = timer_irq_ff;
  assign external_edge_interrupt_o = edge_irq_ff;
endmodule

// ---- pwm_timer_monitor.sv ----
// Purpose: Port checker for pwm_timer
// Assumes: Register writes seen on the port
// Notes: Shadows written registers
`timescale 1ns/100ps
module pwm_timer_monitor (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic measure_input_pin_a_i,
  input wire logic measure_input_pin_b_i,
  input wire logic ring_osc_clock_i,
  input wire logic irq_o,
  input wire logic timer_irq_o,
  input wire logic external_edge_interrupt_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic [7:0] regs_ff [8];
  logic [2:0] off_ff;
  logic lvl;
  assign lvl = regs_ff[3][0] ? measure_input_pin_b_i : measure_input_pin_a_i;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      regs_ff <= '{default: 8'h00};
    end else if (wr_i) begin
      regs_ff[addr_i] <= wdata_i;
    end
  end
  // Cycles spent outside the measured level
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      off_ff <= 3'h0;
    end else if (wr_i || lvl == regs_ff[0][1]) begin
      off_ff <= 3'h0;
    end else if (off_ff != 3'h7) begin
      off_ff <= off_ff + 3'h1;
    end
  end
  idle_rdata_a: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("rdata not idle");
  unmapped_read_a: assert property (rd_i && addr_i > 3'h5 |=> rdata_o == 8'h00)
    else $error("unmapped read not zero");
  mode_bits_a: assert property (rd_i && addr_i == 3'h0 |=> (rdata_o & 8'hcc) == 8'h00)
    else $error("mode unused bits set");
  stop_quiet_a: assert property (!regs_ff[0][0] [*3] |-> !timer_irq_o)
    else $error("underflow while stopped");
  stop_no_edge_a: assert property (!regs_ff[0][0] [*3] |-> !external_edge_interrupt_o)
    else $error("edge irq while stopped");
  gated_hold_a: assert property (off_ff >= 3'h5 |-> !timer_irq_o)
    else $error("underflow while gated");
  uf_flag_a: assert property (timer_irq_o && regs_ff[5][0] |-> ##[0:2] irq_o)
    else $error("underflow not flagged");
  edge_flag_a: assert property (external_edge_interrupt_o && regs_ff[5][1] |-> ##[0:2] irq_o)
    else $error("edge not flagged");
  mask_quiet_a: assert property ((regs_ff[5][1:0] == 2'h0) [*2] |-> !irq_o)
    else $error("irq while masked");
endmodule
bind pwm_timer pwm_timer_monitor i_mon (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .measure_input_pin_a_i(measure_input_pin_a_i),
  .measure_input_pin_b_i(measure_input_pin_b_i), .ring_osc_clock_i(ring_osc_clock_i), .irq_o(irq_o),
  .timer_irq_o(timer_irq_o), .external_edge_interrupt_o(external_edge_interrupt_o));

// ---- pulse_source.sv ----
// Purpose: Measured pulse and ring oscillator model
// Assumes: Bench sets the level of the used pin
// Notes: Unused pin toggles every clock
`timescale 1ns/100ps
module pulse_source (
  input wire logic clk_sys_i,
  input wire logic sel_i,
  input wire logic lvl_i,
  output logic pin_a_o,
  output logic pin_b_o,
  output logic ring_o
);
  logic wob = 1'b0;
  always @(posedge clk_sys_i) begin
    wob <= ~wob;
  end
  assign pin_a_o = sel_i ? wob : lvl_i;
  assign pin_b_o = sel_i ? lvl_i : wob;
  initial begin
    ring_o = 1'b0;
    forever #33 ring_o = ~ring_o;
  end
endmodule

// ---- pwm_timer_bench.sv ----
// Purpose: Self-checking bench for pwm_timer
// Assumes: Pulse source drives the pins
// Notes: Periods checked against a counting model
`timescale 1ns/100ps
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin errors++; $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module pwm_timer_bench;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sel = 1'b0;
  logic lvl = 1'b0;
  logic pa, pb, ring, irq, tirq, eirq;
  logic [7:0] rdata, v, w;
  logic [31:0] rs = 32'h17;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  int divs[$] = '{1, 2, 8};
  pwm_timer i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd),
    .rdata_o(rdata), .measure_input_pin_a_i(pa), .measure_input_pin_b_i(pb), .ring_osc_clock_i(ring),
    .irq_o(irq), .timer_irq_o(tirq), .external_edge_interrupt_o(eirq));
  pulse_source i_src (.clk_sys_i(clk_sys_i), .sel_i(sel), .lvl_i(lvl), .pin_a_o(pa), .pin_b_o(pb), .ring_o(ring));
  initial begin
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  function automatic logic [7:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs[7:0];
  endfunction
  function automatic int model(int p, int t, int d);
    return (p + 1) * (t + 1) * d;
  endfunction
  task automatic wrr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask
  task automatic rdr(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic per(output int c);
    c = 0;
    do begin
      @(posedge clk_sys_i);
      #1;
    end while (tirq !== 1'b1);
    do begin
      @(posedge clk_sys_i);
      #1 c++;
    end while (tirq !== 1'b1 && c < 400);
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end
  initial begin
    repeat (4) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    rdr(3'h2, v);
    `CHK("tmr reset", 8'hff, v)
    repeat (4) begin
      w = rnd();
      wrr(3'h1, w);
      wrr(3'h2, ~w);
      rdr(3'h1, v);
      `CHK("pre", w, v)
      rdr(3'h2, v);
      `CHK("tmr", ~w, v)
    end
    $display("test stopped writes done");
    @(posedge clk_sys_i) lvl <= 1'b1;
    wrr(3'h1, 8'h00);
    wrr(3'h2, 8'h01);
    for (int s = 0; s < 3; s++) begin
      wrr(3'h0, {2'h0, 2'(s), 4'h3});
      per(n);
      per(n);
      `CHK("period", model(0, 1, divs[s]), n)
    end
    wrr(3'h0, 8'h33);
    per(n);
    per(n);
    `CHK("ring period", 1'b1, n inside {[13:14]})
    wrr(3'h0, 8'h03);
    wrr(3'h5, 8'h01);
    wrr(3'h2, 8'h04);
    per(n);
    per(n);
    `CHK("staged", model(0, 4, 1), n)
    `CHK("uf irq", 1'b1, irq)
    wrr(3'h0, 8'h01);
    @(posedge clk_sys_i) lvl <= 1'b0;
    per(n);
    per(n);
    `CHK("low period", model(0, 4, 1), n)
    @(posedge clk_sys_i) lvl <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    rdr(3'h2, v);
    repeat (20) @(posedge clk_sys_i);
    rdr(3'h2, w);
    `CHK("gated hold", v, w)
    wrr(3'h0, 8'h00);
    @(posedge clk_sys_i) lvl <= 1'b0;
    rdr(3'h2, v);
    repeat (20) @(posedge clk_sys_i);
    rdr(3'h2, w);
    `CHK("stop hold", v, w)
    $display("test counting done");
    wrr(3'h3, 8'h01);
    @(posedge clk_sys_i) sel <= 1'b1;
    lvl <= 1'b1;
    wrr(3'h5, 8'h02);
    wrr(3'h0, 8'h03);
    wrr(3'h4, 8'h03);
    @(posedge clk_sys_i) lvl <= 1'b0;
    n = 0;
    while (eirq !== 1'b1 && n < 8) begin
      @(posedge clk_sys_i);
      #1 n++;
    end
    `CHK("edge irq", 1'b1, eirq)
    rdr(3'h4, v);
    `CHK("edge flag", 1'b1, v[1])
    `CHK("irq on", 1'b1, irq)
    wrr(3'h4, 8'h02);
    @(posedge clk_sys_i);
    #1;
    `CHK("irq clear", 1'b0, irq)
    @(posedge clk_sys_i) lvl <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    rdr(3'h4, v);
    `CHK("no entry edge", 1'b0, v[1])
    wrr(3'h6, 8'hff);
    rdr(3'h6, v);
    `CHK("unmapped", 8'h00, v)
    $display("test interrupts done");
    print_verdict();
  end
endmodule
